// *** verilog/srb_pkg.sv ***
package srb_pkg;

  // ==========================================================
  // bus carrier and reset causes
  // ==========================================================
  typedef struct packed {
    logic        read;
    logic        write;
    logic [8:0]  address;     // word index
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } srb_avs_req_t;

  typedef struct packed {
    logic wdt;                // watchdog-caused reset pulse
    logic bod;                // brownout reset pulse
    logic other;              // any other reset cause pulse
  } srb_rst_cause_t;

  // ==========================================================
  // register map
  // ==========================================================
  typedef enum logic [2:0] {
    SRB_K_PLAIN,
    SRB_K_PORT,
    SRB_K_POWER_CONTROL,
    SRB_K_WATCHDOG_CONTROL,
    SRB_K_KEEP
  } srb_kind_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] rst;
    logic [7:0] mask;
    logic       bitable;
    srb_kind_t  kind;
  } srb_desc_t;

  localparam int NREG = 28;

  localparam srb_desc_t SRB_MAP [NREG] = '{
    '{8'h80, 8'h00, 8'hFF, 1'b1, SRB_K_PORT },  // port0_pins
    '{8'h81, 8'h07, 8'hFF, 1'b0, SRB_K_PLAIN},  // stack_pointer
    '{8'h84, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // port0_mode_a
    '{8'h85, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // port0_mode_b
    '{8'h86, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // keyboard_int_mask
    '{8'h87, 8'h00, 8'hFF, 1'b0, SRB_K_POWER_CONTROL },  // power_control
    '{8'h88, 8'h00, 8'hFF, 1'b1, SRB_K_PLAIN},  // timer_control
    '{8'h89, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // timer_mode_select
    '{8'h8A, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // timer0_low_byte
    '{8'h8B, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // timer1_low_byte
    '{8'h8C, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // timer0_high_byte
    '{8'h8D, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // timer1_high_byte
    '{8'h90, 8'h00, 8'hFF, 1'b1, SRB_K_PORT },  // port1_pins
    '{8'h91, 8'h00, 8'hD3, 1'b0, SRB_K_PLAIN},  // port1_mode_a
    '{8'h92, 8'h00, 8'hD3, 1'b0, SRB_K_PLAIN},  // port1_mode_b
    '{8'h98, 8'h00, 8'hFF, 1'b1, SRB_K_PLAIN},  // serial_control
    '{8'h99, 8'h00, 8'hFF, 1'b0, SRB_K_KEEP },  // serial_buffer
    '{8'hA0, 8'h00, 8'h03, 1'b1, SRB_K_PORT },  // port2_pins
    '{8'hA4, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // port2_mode_a
    '{8'hA5, 8'h00, 8'h03, 1'b0, SRB_K_PLAIN},  // port2_mode_b
    '{8'hA6, 8'h00, 8'hFF, 1'b0, SRB_K_KEEP },  // watchdog_feed
    '{8'hA7, 8'h00, 8'h3F, 1'b0, SRB_K_WATCHDOG_CONTROL},  // watchdog_control
    '{8'hA9, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // serial_own_address
    '{8'hB9, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // serial_address_mask
    '{8'hD0, 8'h00, 8'hFF, 1'b1, SRB_K_PLAIN},  // program_status_word
    '{8'hF6, 8'h00, 8'hFF, 1'b0, SRB_K_PLAIN},  // port0_analog_input_disable
    '{8'hF7, 8'h00, 8'hB7, 1'b0, SRB_K_PLAIN},  // irq_priority_high_b
    '{8'hF8, 8'h00, 8'hB7, 1'b1, SRB_K_PLAIN}   // irq_priority_low_b
  };

  // ==========================================================
  // fields and reset values
  // ==========================================================
  localparam logic [7:0] SRB_POWER_CONTROL_BOF     = 8'h20;
  localparam logic [7:0] SRB_POWER_CONTROL_POF     = 8'h10;
  localparam logic [7:0] SRB_POWER_CONTROL_LOW     = 8'h0F;
  localparam logic [7:0] SRB_PORT_FILL    = 8'hFF;
  localparam int         SRB_PORT_RESET_LEVEL_SELECT_BIT     = 0;
  localparam logic [7:0] SRB_WATCHDOG_CONTROL_RST_WD = 8'h20;   // after a watchdog reset
  localparam logic [7:0] SRB_WATCHDOG_CONTROL_RST_EN = 8'h10;   // other cause, watchdog on
  localparam logic [7:0] SRB_WATCHDOG_CONTROL_RST_DS = 8'h00;   // other cause, watchdog off

  // ==========================================================
  // block-own registers (word indices)
  // ==========================================================
  localparam logic [8:0] SRB_A_BITOP   = 9'h100;
  localparam logic [8:0] SRB_A_IRQ_ST  = 9'h101;
  localparam logic [8:0] SRB_A_IRQ_CLR = 9'h102;
  localparam logic [8:0] SRB_A_IRQ_EN  = 9'h103;
  localparam logic [1:0] SRB_BIT_SET   = 2'h1;
  localparam logic [1:0] SRB_BIT_CLR   = 2'h2;
  localparam int         SRB_NEV       = 3;
  localparam int         SRB_EV_BOF    = 0;
  localparam int         SRB_EV_WDT    = 1;
  localparam int         SRB_EV_UNMAP  = 2;

endpackage

// *** verilog/srb_bank.sv ***
`timescale 1ns/100ps
// What this block does
// - bit-addressable registers support single-bit set, clear, test
// - unimplemented bits read unspecified; here read zero
// - port latch reset level from configuration option bit
// - power control: top kept, flags kept, low zero
// - brownout and power-on flags survive every reset
// - power-on flag set at supply power-up
// - brownout flag set by brownout and power-up
// - watchdog control reset value depends on cause
module srb_bank (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rstn_i,
  input  wire srb_pkg::srb_avs_req_t   avs_req_i,
  output logic                         avs_waitrequest_o,
  output logic [31:0]                  avs_readdata_o,
  input  wire srb_pkg::srb_rst_cause_t rst_cause_i,
  input  wire logic                    bod_irq_i,
  input  wire logic                    wdt_enabled_i,
  input  wire logic [7:0]              user_config_byte_one_i,
  output logic [srb_pkg::NREG*8-1:0]   sfr_o,
  output logic                         irq_o
);
  import srb_pkg::*;

  // ==========================================================
  // bus handshake
  // ==========================================================
  logic                wait_q;
  logic [31:0]         rdata_q;
  logic                init_q;
  logic [7:0]          regs_q [NREG];
  logic [7:0]          bitsel_q;
  logic [SRB_NEV-1:0]  irq_st_q;
  logic [SRB_NEV-1:0]  irq_en_q;
  logic                irq_q;

  // request seen while idle, and the edge the master completes on
  wire        req_any  = avs_req_i.read | avs_req_i.write;
  wire        acc      = req_any & wait_q;
  wire        done     = req_any & ~wait_q;
  wire        wr_done  = done & avs_req_i.write;
  wire [8:0]  addr     = avs_req_i.address;
  wire [7:0]  wdata8   = avs_req_i.writedata[7:0];
  wire        be0      = avs_req_i.byteenable[0];

  // own-register decode
  wire        sel_bitop  = addr == SRB_A_BITOP;
  wire        sel_st     = addr == SRB_A_IRQ_ST;
  wire        sel_clr    = addr == SRB_A_IRQ_CLR;
  wire        sel_en     = addr == SRB_A_IRQ_EN;
  wire        sel_sfr    = addr[8] == 1'b0;

  // ==========================================================
  // reset causes
  // ==========================================================
  // init_q stands in for the power-up cause in the first cycle after
  // release: async reset may only load constants, so strap-dependent
  // values are caught here one edge later.
  wire        any_rst  = init_q | rst_cause_i.wdt | rst_cause_i.bod | rst_cause_i.other;
  wire        port_reset_level_select     = user_config_byte_one_i[SRB_PORT_RESET_LEVEL_SELECT_BIT];
  wire [7:0]  port_rst = port_reset_level_select ? SRB_PORT_FILL : 8'h00;
  wire [7:0]  watchdog_control_rst = rst_cause_i.wdt ? SRB_WATCHDOG_CONTROL_RST_WD :
                          wdt_enabled_i   ? SRB_WATCHDOG_CONTROL_RST_EN :
                                            SRB_WATCHDOG_CONTROL_RST_DS;
  wire        bof_set  = bod_irq_i | rst_cause_i.bod;

  // ==========================================================
  // single-bit access command
  // ==========================================================
  // bit address = byte address of a bit-addressable register + bit
  wire        bit_wr   = wr_done & sel_bitop & be0;
  wire [1:0]  bit_op   = avs_req_i.writedata[9:8];
  wire [7:0]  bit_tgt  = wdata8;
  wire [7:0]  bit_reg  = {bit_tgt[7:3], 3'h0};
  wire [7:0]  bit_one  = 8'h01 << bit_tgt[2:0];
  wire [7:0]  tst_reg  = {bitsel_q[7:3], 3'h0};
  wire [2:0]  tst_pos  = bitsel_q[2:0];

  // ==========================================================
  // register array
  // ==========================================================
  logic [7:0] rd_chain  [NREG+1];
  logic       hit_chain [NREG+1];
  logic       tst_chain [NREG+1];

  assign rd_chain[0]  = 8'h00;
  assign hit_chain[0] = 1'b0;
  assign tst_chain[0] = 1'b0;

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    localparam srb_desc_t D = SRB_MAP[i];
    wire        here     = sel_sfr & (addr[7:0] == D.idx);
    wire        byte_hit = wr_done & here & be0;
    wire        bit_hit  = bit_wr & D.bitable & (bit_reg == D.idx);
    wire [7:0]  bit_val  = (bit_op == SRB_BIT_SET) ? (regs_q[i] | bit_one) :
                           (bit_op == SRB_BIT_CLR) ? (regs_q[i] & ~bit_one) :
                                                     regs_q[i];
    wire [7:0]  sw_val   = byte_hit ? wdata8 : bit_hit ? bit_val : regs_q[i];
    // hardware flag sets are or-ed after software, so a set wins
    wire [7:0]  hw_set   = (D.kind == SRB_K_POWER_CONTROL && bof_set) ? SRB_POWER_CONTROL_BOF : 8'h00;
    wire [7:0]  run_val  = (sw_val & D.mask) | hw_set;
    wire [7:0]  keep_hi  = regs_q[i] & ~SRB_POWER_CONTROL_LOW;
    wire [7:0]  power_control_rst = keep_hi | hw_set;
    wire [7:0]  rst_val  = (D.kind == SRB_K_PORT)  ? (port_rst & D.mask) :
                           (D.kind == SRB_K_POWER_CONTROL)  ? power_control_rst :
                           (D.kind == SRB_K_WATCHDOG_CONTROL) ? (watchdog_control_rst & D.mask) :
                           (D.kind == SRB_K_KEEP)  ? regs_q[i] :
                                                     D.rst;
    wire [7:0]  d_val    = any_rst ? rst_val : run_val;
    // power-up constant: both supply flags set, the rest cleared
    localparam logic [7:0] PWR = (D.kind == SRB_K_POWER_CONTROL)  ? (SRB_POWER_CONTROL_BOF | SRB_POWER_CONTROL_POF) :
                                 (D.kind == SRB_K_WATCHDOG_CONTROL) ? SRB_WATCHDOG_CONTROL_RST_DS :
                                                           (D.rst & D.mask);

    // the only async load is the supply coming up
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        regs_q[i] <= PWR;
      end else begin
        regs_q[i] <= d_val;
      end
    end

    // read and bit-test muxes, unimplemented bits read as zero
    assign rd_chain[i+1]  = rd_chain[i] | (here ? (regs_q[i] & D.mask) : 8'h00);
    assign hit_chain[i+1] = hit_chain[i] | here;
    assign tst_chain[i+1] = tst_chain[i] |
                            (D.bitable && tst_reg == D.idx && regs_q[i][tst_pos]);
    assign sfr_o[i*8 +: 8] = regs_q[i];
  end

  // ==========================================================
  // interrupt status, clear and enable
  // ==========================================================
  wire                unmapped = done & ~(sel_bitop | sel_st | sel_clr | sel_en |
                                          hit_chain[NREG]);
  wire [SRB_NEV-1:0]  events   = {unmapped, rst_cause_i.wdt, bof_set};
  wire [SRB_NEV-1:0]  clr_bits = (wr_done & sel_clr & be0) ? wdata8[SRB_NEV-1:0]
                                                          : {SRB_NEV{1'b0}};
  wire [SRB_NEV-1:0]  st_d     = (irq_st_q & ~clr_bits) | events;

  // status is cleared only by the supply reset and by writes to the clear register, so causes stay visible
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st_q <= {SRB_NEV{1'b0}};
      irq_en_q <= {SRB_NEV{1'b0}};
      irq_q    <= 1'b0;
    end else begin
      irq_st_q <= st_d;
      if (wr_done && sel_en && be0) begin
        irq_en_q <= wdata8[SRB_NEV-1:0];
      end
      irq_q    <= |(irq_st_q & irq_en_q);
    end
  end

  // ==========================================================
  // read data and waitrequest
  // ==========================================================
  wire [31:0] rd_own  = sel_bitop ? {23'h0, tst_chain[NREG], bitsel_q} :
                        sel_st    ? {{(32-SRB_NEV){1'b0}}, irq_st_q} :
                        sel_en    ? {{(32-SRB_NEV){1'b0}}, irq_en_q} :
                                    32'h0000_0000;
  wire [31:0] rd_word = sel_sfr ? {24'h00_0000, rd_chain[NREG]} : rd_own;

  // one wait cycle: low for exactly one cycle per request
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q   <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      init_q   <= 1'b1;
      bitsel_q <= 8'h00;
    end else begin
      wait_q   <= ~acc;
      init_q   <= 1'b0;
      if (acc && avs_req_i.read) begin
        rdata_q <= rd_word;
      end
      if (bit_wr) begin
        bitsel_q <= bit_tgt;
      end
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  assign irq_o             = irq_q;

endmodule

// *** verification/srb_bank_asserts.sv ***
`timescale 1ns/100ps
module srb_bank_asserts (
  input wire logic                       clk_sys_i,
  input wire logic                       rstn_i,
  input wire srb_pkg::srb_avs_req_t      avs_req_i,
  input wire logic                       avs_waitrequest_o,
  input wire logic [31:0]                avs_readdata_o,
  input wire srb_pkg::srb_rst_cause_t    rst_cause_i,
  input wire logic                       bod_irq_i,
  input wire logic                       wdt_enabled_i,
  input wire logic [7:0]                 user_config_byte_one_i,
  input wire logic [srb_pkg::NREG*8-1:0] sfr_o,
  input wire logic                       irq_o
);
  import srb_pkg::*;
  // ==========================================================
  // watched bytes and events
  // ==========================================================
  // only a completing byte write may move the power-on flag
  logic [7:0] power_control;
  logic       any_rst;
  logic       power_control_wr;
  assign power_control    = sfr_o[5*8+:8];
  assign any_rst = |rst_cause_i;
  assign power_control_wr = avs_req_i.write && !avs_waitrequest_o && avs_req_i.address == 9'h087;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // bus answer and reset behaviour
  // ==========================================================
  bus_answer_a: assert property (
    (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  answer_pulse_a: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer held too long");
  pof_hold_a: assert property (
    !power_control_wr |=> $stable(power_control[4])) else $error("power-on flag moved");
  bof_set_a: assert property (
    bod_irq_i || rst_cause_i.bod |=> power_control[5]) else $error("brownout flag not set");
  power_control_reset_a: assert property (
    any_rst |=> power_control[3:0] == 4'h0 && power_control[7:6] == $past(power_control[7:6]))
    else $error("power control reset value wrong");
  watchdog_control_wdt_a: assert property (
    rst_cause_i.wdt |=> sfr_o[21*8+:8] == SRB_WATCHDOG_CONTROL_RST_WD)
    else $error("watchdog control not at watchdog reset value");
  port_reset_a: assert property (
    any_rst |=> sfr_o[7:0] == ($past(user_config_byte_one_i[0]) ? 8'hFF : 8'h00))
    else $error("port latch reset level wrong");
  plain_reset_a: assert property (
    any_rst |=> sfr_o[15:8] == 8'h07 && sfr_o[6*8+:8] == 8'h00)
    else $error("listed reset value not loaded");
  // main scenarios reached
  cover property (rst_cause_i.wdt);
  cover property (bod_irq_i);
  cover property (irq_o);
endmodule

// *** verification/srb_bank_tb_top.sv ***
`timescale 1ns/100ps
module srb_bank_tb_top;
  import srb_pkg::*;
  logic                clk_sys_i = 1'b0;
  logic                rstn_i    = 1'b0;
  srb_avs_req_t        req       = '0;
  srb_rst_cause_t      cause     = '0;
  logic                bod       = 1'b0;
  logic                wen       = 1'b1;
  logic [7:0]          cfg       = 8'h01;
  logic                wreq;
  logic [31:0]         rdata;
  logic [NREG*8-1:0]   sfr;
  logic                irq;
  logic [31:0]         q;
  logic [7:0]          bits [7] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'hA0, 8'hD0, 8'hF8};
  int                  error_cnt   = 0;
  int                  checks_done = 0;
  int                  cyc         = 0;
  srb_bank DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_req_i(req),
    .avs_waitrequest_o(wreq), .avs_readdata_o(rdata), .rst_cause_i(cause),
    .bod_irq_i(bod), .wdt_enabled_i(wen), .user_config_byte_one_i(cfg),
    .sfr_o(sfr), .irq_o(irq));
  always #25 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // bench tasks
  // ==========================================================
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{!w, w, a, d, 4'h1};
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    q = rdata;
    req <= '0;
  endtask
  task automatic rc(input logic [8:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic pulse(input srb_rst_cause_t c, input logic b);
    @(posedge clk_sys_i);
    cause <= c;
    bod   <= b;
    @(posedge clk_sys_i);
    cause <= '0;
    bod   <= 1'b0;
  endtask
  // hang guard, about eighteen times the expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================================
  // scenarios
  // ==========================================================
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rc(9'h081, 32'h07);
    rc(9'h080, 32'hFF);
    rc(9'h0A0, 32'h03);
    rc(9'h087, 32'h30);
    rc(9'h0A7, 32'h10);
    // only implemented bit positions carry ones, the rest are written zero
    acc(1'b1, 9'h091, 32'hD3);
    rc(9'h091, 32'hD3);
    // flags and top bits survive a plain reset, low bits clear
    acc(1'b1, 9'h087, 32'hFF);
    acc(1'b1, 9'h081, 32'h55);
    cfg <= 8'h00;
    wen <= 1'b0;
    pulse('{1'b0, 1'b0, 1'b1}, 1'b0);
    rc(9'h087, 32'hF0);
    rc(9'h081, 32'h07);
    rc(9'h080, 32'h00);
    rc(9'h0A7, 32'h00);
    // cleared flags must not come back through a watchdog reset
    acc(1'b1, 9'h087, 32'h00);
    pulse('{1'b1, 1'b0, 1'b0}, 1'b0);
    rc(9'h0A7, 32'h20);
    rc(9'h087, 32'h00);
    pulse('{1'b0, 1'b1, 1'b0}, 1'b0);
    rc(9'h087, 32'h20);
    acc(1'b1, 9'h087, 32'h00);
    pulse('0, 1'b1);
    rc(9'h087, 32'h20);
    // interrupt status, unmapped access, mask and clear
    rc(9'h101, 32'h03);
    rc(9'h0FF, 32'h00);
    rc(9'h101, 32'h07);
    acc(1'b1, 9'h103, 32'h04);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, 9'h103, 32'h00);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, 9'h103, 32'h04);
    acc(1'b1, 9'h102, 32'h07);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    rc(9'h101, 32'h00);
    // single-bit set, test and clear on every bit-addressable byte
    foreach (bits[i]) begin
      acc(1'b1, 9'h100, {22'h0, 2'h1, bits[i] + 8'h01});
      rc(9'h100, {23'h0, 1'b1, bits[i] + 8'h01});
      rc({1'b0, bits[i]}, 32'h02);
      acc(1'b1, 9'h100, {22'h0, 2'h2, bits[i] + 8'h01});
      rc({1'b0, bits[i]}, 32'h00);
    end
    // select-only bit command tests a bit set by a byte write
    acc(1'b1, 9'h0D0, 32'h01);
    acc(1'b1, 9'h100, 32'h0D0);
    rc(9'h100, 32'h1D0);
    end_sim();
  end
endmodule
bind srb_bank srb_bank_asserts u_chk (.clk_sys_i, .rstn_i, .avs_req_i, .avs_waitrequest_o,
  .avs_readdata_o, .rst_cause_i, .bod_irq_i, .wdt_enabled_i, .user_config_byte_one_i,
  .sfr_o, .irq_o);
